// ==== rtl/tcm_timer.sv ====
// Purpose: 16-bit timer with one capture/compare channel on an AHB-Lite slave
// Assumes: single slave on the bus, hclk 250 MHz, low-power and break as inputs
// Notes:   zero-wait writes, one-wait reads, response always OKAY
// Function
// - counts in wait, bus locked out
// - enabled requests wake processor from wait
// - stop mode freezes everything, values kept
// - resume from kept state after stop
// - break holds the counter
// - break clear enable lets clears stick
// - otherwise break protects flags and arming
// - channel pin is capture or compare
// - edge level 00 presets output level
// - mode 00 captures rising, falling, both
// - mode 01 toggle, clear, set on match
// - mode 1X buffered compare, same actions
// - overflow toggle on compare, reset clear
// - overflow beats simultaneous compare match
// - full duty force gives 100 percent
// - full duty change applies next period
// - overflow flag at modulo, interrupt request
// - channel flag on event, interrupt request
// - counter read never disturbs counting
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

`include "tcm_consts.svh"

module tcm_timer #(
  parameter int CNT_W = `TCM_CNT_W
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        break_active,
  input  wire logic        channel0_pin_in,
  output logic             channel0_pin_out,
  output logic             channel0_pin_oe_n,
  output logic             irq_request,
  output logic             wake_request
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W != `TCM_CNT_W) begin : g_width_check
    $error("tcm_timer: CNT_W must equal the state struct width");
  end

  tcm_pkg::tcm_state_t st;
  tcm_pkg::tcm_state_t next_st;
  tcm_pkg::tcm_edges_t edges;

  logic            tick;
  logic            ovf;
  logic            match;
  logic            is_capt;
  logic            is_oc;
  logic            capt_evt;
  logic            protect;
  logic            accept;
  logic            wr_flag;
  logic [CNT_W-1:0] wval;
  logic [31:0]     rmux;

  tcm_edge_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (channel0_pin_in),
    .edges   (edges)
  );

  // ----------------------------------------------------------------
  // decode of channel mode and counter events
  // ----------------------------------------------------------------
  always_comb begin
    // counter halts for software stop, break and stop mode, not for wait
    tick     = ~st.ctl.cnt_stop & ~break_active & ~stop_mode;
    ovf      = tick & (st.count == st.modulo);
    is_capt  = (st.ctl.mode == `TCM_MODE_CAPT) & (st.ctl.edge_lvl != `TCM_EL_OFF);
    is_oc    = (st.ctl.mode != `TCM_MODE_CAPT) & (st.ctl.edge_lvl != `TCM_EL_OFF);
    match    = tick & is_oc & (st.count == st.ch_value);
    capt_evt = ~stop_mode & is_capt
             & ((st.ctl.edge_lvl[0] & edges.rise)
              | (st.ctl.edge_lvl[1] & edges.fall));
    protect  = break_active & ~st.ctl.break_clear_enable;
    accept   = hsel & hready & htrans[`TCM_HTRANS_NSEQ]
             & ~wait_mode & ~stop_mode;
    wval     = hwdata[CNT_W-1:0];
  end

  // ----------------------------------------------------------------
  // read mux, sampled into hrdata in the read wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    rmux = 32'h0;
    unique case (st.addr)
      `TCM_OFS_CTRL: begin
        rmux[`TCM_CTRL_FLAG] = st.ctl.ovf_flag;
        rmux[`TCM_CTRL_IE]   = st.ctl.ovf_ie;
        rmux[`TCM_CTRL_STOP] = st.ctl.cnt_stop;
      end
      `TCM_OFS_COUNT:    rmux[CNT_W-1:0] = st.count;
      `TCM_OFS_MODULO:   rmux[CNT_W-1:0] = st.modulo;
      `TCM_OFS_CH_CTRL: begin
        rmux[`TCM_CH_FLAG] = st.ctl.ch_flag;
        rmux[`TCM_CH_IE]   = st.ctl.ch_ie;
        rmux[`TCM_CH_MODE_HI:`TCM_CH_MODE_LO] = st.ctl.mode;
        rmux[`TCM_CH_EL_HI:`TCM_CH_EL_LO]     = st.ctl.edge_lvl;
        rmux[`TCM_CH_TOV] = st.ctl.tov;
        rmux[`TCM_CH_MAX] = st.ctl.max_req;
      end
      `TCM_OFS_CH_VALUE: rmux[CNT_W-1:0] = st.ch_value;
      `TCM_OFS_SYSCFG:   rmux[`TCM_SYS_BREAK_CLEAR_ENABLE] = st.ctl.break_clear_enable;
      default:           rmux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    wr_flag = 1'b0;

    // bus phase tracking; reads take one wait cycle
    unique case (st.phase)
      tcm_pkg::TCM_PH_IDLE: begin
      end
      tcm_pkg::TCM_PH_WRITE: begin
        next_st.phase = tcm_pkg::TCM_PH_IDLE;
        wr_flag       = 1'b1;
      end
      tcm_pkg::TCM_PH_READ: begin
        next_st.phase = tcm_pkg::TCM_PH_IDLE;
        next_st.rdata = rmux;
        // first step of a two-step clear, not taken while protected
        if (!protect) begin
          if (st.addr == `TCM_OFS_CTRL && st.ctl.ovf_flag) begin
            next_st.ctl.ovf_armed = 1'b1;
          end
          if (st.addr == `TCM_OFS_CH_CTRL && st.ctl.ch_flag) begin
            next_st.ctl.ch_armed = 1'b1;
          end
        end
      end
    endcase
    if (accept && st.phase != tcm_pkg::TCM_PH_READ) begin
      next_st.addr  = haddr[`TCM_ADDR_W-1:0];
      next_st.phase = hwrite ? tcm_pkg::TCM_PH_WRITE : tcm_pkg::TCM_PH_READ;
    end

    // register writes in the data phase
    if (wr_flag) begin
      unique case (st.addr)
        `TCM_OFS_CTRL: begin
          next_st.ctl.ovf_ie   = hwdata[`TCM_CTRL_IE];
          next_st.ctl.cnt_stop = hwdata[`TCM_CTRL_STOP];
          if (!hwdata[`TCM_CTRL_FLAG] && st.ctl.ovf_armed && !protect) begin
            next_st.ctl.ovf_flag  = 1'b0;
            next_st.ctl.ovf_armed = 1'b0;
          end
          if (hwdata[`TCM_CTRL_RST]) begin
            next_st.count = '0;
          end
        end
        `TCM_OFS_MODULO: next_st.modulo = wval;
        `TCM_OFS_CH_CTRL: begin
          next_st.ctl.ch_ie    = hwdata[`TCM_CH_IE];
          next_st.ctl.mode     = hwdata[`TCM_CH_MODE_HI:`TCM_CH_MODE_LO];
          next_st.ctl.edge_lvl = hwdata[`TCM_CH_EL_HI:`TCM_CH_EL_LO];
          next_st.ctl.tov      = hwdata[`TCM_CH_TOV];
          next_st.ctl.max_req  = hwdata[`TCM_CH_MAX];
          if (!hwdata[`TCM_CH_FLAG] && st.ctl.ch_armed && !protect) begin
            next_st.ctl.ch_flag  = 1'b0;
            next_st.ctl.ch_armed = 1'b0;
          end
        end
        `TCM_OFS_CH_VALUE: begin
          // buffered mode parks the value until the period ends
          if (st.ctl.mode[1]) begin
            next_st.ch_buf       = wval;
            next_st.ctl.buf_pend = 1'b1;
          end else begin
            next_st.ch_value = wval;
          end
        end
        `TCM_OFS_SYSCFG: next_st.ctl.break_clear_enable = hwdata[`TCM_SYS_BREAK_CLEAR_ENABLE];
        default: begin
        end
      endcase
    end

    // counter; a counter reset write still wins over a tick
    if (tick && !(wr_flag && st.addr == `TCM_OFS_CTRL && hwdata[`TCM_CTRL_RST])) begin
      next_st.count = ovf ? '0 : st.count + 1'b1;
    end

    // hardware set wins over a same-cycle software clear
    if (ovf) begin
      next_st.ctl.ovf_flag = 1'b1;
    end
    if (capt_evt) begin
      next_st.ch_value = st.count;
    end
    if (capt_evt || match) begin
      next_st.ctl.ch_flag = 1'b1;
    end

    // period boundary: buffered value and full-duty request take effect
    if (ovf) begin
      next_st.ctl.max_eff = st.ctl.max_req;
      if (st.ctl.buf_pend) begin
        next_st.ch_value     = st.ch_buf;
        next_st.ctl.buf_pend = 1'b0;
      end
    end

    // channel output level
    if (st.ctl.edge_lvl == `TCM_EL_OFF) begin
      next_st.ctl.level = ~st.ctl.mode[0];
    end else if (is_oc) begin
      if (ovf && st.ctl.tov) begin
        next_st.ctl.level = ~st.ctl.level;
      end else if (match) begin
        unique case (st.ctl.edge_lvl)
          `TCM_EL_TOGGLE: next_st.ctl.level = ~st.ctl.level;
          `TCM_EL_CLEAR:  next_st.ctl.level = 1'b0;
          `TCM_EL_SET:    next_st.ctl.level = 1'b1;
          default:        next_st.ctl.level = st.ctl.level;
        endcase
      end
    end

    // stop mode freezes the whole block
    if (stop_mode) begin
      next_st = st;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st              <= '0;
      st.modulo       <= `TCM_MODULO_RST;
      st.ctl.cnt_stop <= `TCM_STOP_RST;
      st.phase        <= tcm_pkg::TCM_PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    hreadyout         = (st.phase != tcm_pkg::TCM_PH_READ);
    hresp             = 1'b0;
    hrdata            = st.rdata;
    // forced level holds through the whole period, hence 100 percent
    channel0_pin_out  = (is_oc & st.ctl.tov & st.ctl.max_eff) | st.ctl.level;
    channel0_pin_oe_n = ~is_oc;
    irq_request       = (st.ctl.ovf_flag & st.ctl.ovf_ie)
                      | (st.ctl.ch_flag & st.ctl.ch_ie);
    wake_request      = irq_request & wait_mode;
  end

endmodule : tcm_timer

// ==== rtl/tcm_consts.svh ====
// Purpose: offsets, field positions, reset values of the timer channel block
// Assumes: 32-bit bus words, one register per aligned word
// Notes:   byte offsets within the block's window
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define TCM_CNT_W        16
`define TCM_ADDR_W       8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCM_OFS_CTRL     8'h00
`define TCM_OFS_COUNT    8'h04
`define TCM_OFS_MODULO   8'h08
`define TCM_OFS_CH_CTRL  8'h0c
`define TCM_OFS_CH_VALUE 8'h10
`define TCM_OFS_SYSCFG   8'h14

// ----------------------------------------------------------------
// control / status fields
// ----------------------------------------------------------------
`define TCM_CTRL_FLAG    7
`define TCM_CTRL_IE      6
`define TCM_CTRL_STOP    5
`define TCM_CTRL_RST     4
`define TCM_CH_FLAG      7
`define TCM_CH_IE        6
`define TCM_CH_MODE_HI   5
`define TCM_CH_MODE_LO   4
`define TCM_CH_EL_HI     3
`define TCM_CH_EL_LO     2
`define TCM_CH_TOV       1
`define TCM_CH_MAX       0
`define TCM_SYS_BREAK_CLEAR_ENABLE     0

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define TCM_MODULO_RST   16'hffff
`define TCM_STOP_RST     1'h1
`define TCM_MODE_CAPT    2'h0
`define TCM_EL_OFF       2'h0
`define TCM_EL_TOGGLE    2'h1
`define TCM_EL_CLEAR     2'h2
`define TCM_EL_SET       2'h3
`define TCM_HTRANS_NSEQ  1

`endif

// ==== rtl/tcm_pkg.sv ====
// Purpose: types of the timer channel block
// Assumes: tcm_consts.svh gives the widths
// Notes:   whole module state is one packed struct
`include "tcm_consts.svh"

package tcm_pkg;

  typedef enum logic [2:0] {
    TCM_PH_IDLE  = 3'h1,
    TCM_PH_WRITE = 3'h2,
    TCM_PH_READ  = 3'h4
  } tcm_phase_t;

  typedef struct packed {
    logic                  ovf_flag;
    logic                  ovf_armed;
    logic                  ovf_ie;
    logic                  cnt_stop;
    logic                  ch_flag;
    logic                  ch_armed;
    logic                  ch_ie;
    logic [1:0]            mode;
    logic [1:0]            edge_lvl;
    logic                  tov;
    logic                  max_req;
    logic                  max_eff;
    logic                  level;
    logic                  buf_pend;
    logic                  break_clear_enable;
  } tcm_ctl_t;

  typedef struct packed {
    logic [`TCM_CNT_W-1:0]  count;
    logic [`TCM_CNT_W-1:0]  modulo;
    logic [`TCM_CNT_W-1:0]  ch_value;
    logic [`TCM_CNT_W-1:0]  ch_buf;
    tcm_ctl_t               ctl;
    tcm_phase_t             phase;
    logic [`TCM_ADDR_W-1:0] addr;
    logic [31:0]            rdata;
  } tcm_state_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tcm_edges_t;

endpackage : tcm_pkg

// ==== rtl/tcm_edge_sync.sv ====
// Purpose: bring the channel pin into the bus clock and find its edges
// Assumes: pin is asynchronous to hclk
// Notes:   one pulse per qualifying edge
`timescale 1ns/1ps

module tcm_edge_sync (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         pin_in,
  output tcm_pkg::tcm_edges_t edges
);

  logic [2:0] sync;

  // ----------------------------------------------------------------
  // two-stage synchroniser, third stage only for edge compare
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // line idles high on its pull-up; a low reset value fakes a rise
      sync <= 3'h7;
    end else begin
      sync <= {sync[1:0], pin_in};
    end
  end

  // edges look only at stages two and three
  always_comb begin
    edges.rise = sync[1] & ~sync[2];
    edges.fall = ~sync[1] & sync[2];
  end

endmodule : tcm_edge_sync

// ==== verification/tcm_timer_monitor.sv ====
// Purpose: port checks of the timer channel block
// Assumes: hready looped back from hreadyout, one slave
// Notes:   bound to every tcm_timer instance
`timescale 1ns/1ps

module tcm_timer_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        channel0_pin_out,
  input wire logic        channel0_pin_oe_n,
  input wire logic        irq_request,
  input wire logic        wake_request
);
  // ------------------
  // bus and low power
  // ------------------
  logic req;
  logic take;

  assign req  = hsel & hready & htrans[1];
  assign take = req & !wait_mode & !stop_mode;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_WRITE_NOWAIT:
    assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_READ_ONEWAIT:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  AST_LOCKED_OUT:
    assert property (req && (wait_mode || stop_mode) |=> hreadyout && $stable(hrdata))
    else $error("access taken while locked");
  AST_RDATA_HOLD:
    assert property ($changed(hrdata) |-> $past(take && !hwrite, 2))
    else $error("read data moved without read");
  AST_WAKE_EQ:
    assert property (wake_request == (irq_request && wait_mode))
    else $error("wake request wrong");
  AST_STOP_FROZEN:
    assert property (stop_mode |=> $stable({channel0_pin_out, channel0_pin_oe_n, irq_request}))
    else $error("outputs moved in stop");
  AST_HIGH_ZERO:
    assert property (hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_HRESP_OKAY:
    assert property (hresp == 1'h0)
    else $error("response not okay");
endmodule : tcm_timer_monitor

bind tcm_timer tcm_timer_monitor i_mon (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .wait_mode, .stop_mode, .channel0_pin_out, .channel0_pin_oe_n, .irq_request,
  .wake_request
);

// ==== verification/tcm_pin_model.sv ====
// Purpose: source and load on the channel pin
// Assumes: pull-up on the line
// Notes:   counts rises and low cycles while the block drives
`timescale 1ns/1ps

module tcm_pin_model (
  input  wire logic hclk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic src_en,
  input  wire logic src_lvl,
  input  wire logic clr,
  output logic      pin_in,
  output int        rises,
  output int        lows
);
  logic last;

  // block wins when enabled, else source, else pull-up
  always_comb pin_in = !pin_oe_n ? pin_out : (src_en ? src_lvl : 1'h1);

  always @(posedge hclk) begin
    last <= pin_in;
    if (clr) begin
      rises <= 0;
      lows  <= 0;
    end else if (!pin_oe_n) begin
      rises <= rises + int'(pin_in && !last);
      lows  <= lows + int'(!pin_in);
    end
  end
endmodule : tcm_pin_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench of the timer block
// Assumes: hready looped back, pin model on channel 0
// Notes:   modulo 0xf keeps compare periods short
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tb_top;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic        wait_mode = 1'h0;
  logic        stop_mode = 1'h0;
  logic        break_active = 1'h0;
  logic        src_en = 1'h0;
  logic        src_lvl = 1'h0;
  logic        clr = 1'h1;
  logic        hreadyout, hresp, pin_in, pin_out, pin_oe_n, irq_request, wake_request;
  logic [31:0] hrdata, v, w;
  int          rises, lows;
  int          cyc = 0;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #2 hclk = ~hclk;

  tcm_timer i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wait_mode, .stop_mode,
    .break_active, .channel0_pin_in(pin_in), .channel0_pin_out(pin_out),
    .channel0_pin_oe_n(pin_oe_n), .irq_request, .wake_request
  );

  tcm_pin_model i_pin (
    .hclk, .pin_out, .pin_oe_n, .src_en, .src_lvl, .clr, .pin_in, .rises, .lows
  );

  // ------------------
  // helpers
  // ------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    v = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask : rd

  // settle, then count pin activity for n cycles
  task automatic span(input int n);
    repeat (40) @(posedge hclk);
    clr <= 1'h1;
    @(posedge hclk);
    clr <= 1'h0;
    repeat (n) @(posedge hclk);
  endtask : span

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // ------------------
  // scenarios
  // ------------------
  task automatic t_reset;
    rd(`TCM_OFS_CTRL);
    chk(v, 32'h20);
    rd(`TCM_OFS_MODULO);
    chk(v, 32'hffff);
    rd(`TCM_OFS_CH_CTRL);
    chk(v, 32'h0);
    rd(8'h18);
    chk(v, 32'h0);
  endtask : t_reset

  task automatic t_power;
    wr(`TCM_OFS_CTRL, 32'h0);
    rd(`TCM_OFS_COUNT);
    w = v;
    wait_mode <= 1'h1;
    repeat (50) @(posedge hclk);
    wr(`TCM_OFS_MODULO, 32'h1234);
    wait_mode <= 1'h0;
    rd(`TCM_OFS_COUNT);
    chk(v - w > 32'h32, 32'h1);
    rd(`TCM_OFS_MODULO);
    chk(v, 32'hffff);
    for (int i = 0; i < 2; i++) begin
      rd(`TCM_OFS_COUNT);
      w = v;
      stop_mode <= (i == 0);
      break_active <= (i == 1);
      repeat (100) @(posedge hclk);
      stop_mode <= 1'h0;
      break_active <= 1'h0;
      rd(`TCM_OFS_COUNT);
      chk(v - w < 32'h10 && v != w, 32'h1);
    end
    // software parks an unused timer before wait
    wr(`TCM_OFS_CTRL, 32'h20);
    rd(`TCM_OFS_COUNT);
    w = v;
    wait_mode <= 1'h1;
    repeat (20) @(posedge hclk);
    wait_mode <= 1'h0;
    rd(`TCM_OFS_COUNT);
    chk(v, w);
  endtask : t_power

  task automatic t_flags;
    wr(`TCM_OFS_MODULO, 32'hf);
    for (int b = 0; b < 2; b++) begin
      wr(`TCM_OFS_SYSCFG, 32'(b));
      wr(`TCM_OFS_CTRL, 32'h50);
      repeat (20) @(posedge hclk);
      chk(irq_request, 1'h1);
      wait_mode <= 1'h1;
      repeat (2) @(posedge hclk);
      chk(wake_request, 1'h1);
      wait_mode <= 1'h0;
      wr(`TCM_OFS_CTRL, 32'he0);
      break_active <= b[0];
      rd(`TCM_OFS_CTRL);
      chk(v, 32'he0);
      break_active <= 1'h1;
      wr(`TCM_OFS_CTRL, 32'h60);
      rd(`TCM_OFS_CTRL);
      chk(v, b ? 32'h60 : 32'he0);
      break_active <= 1'h0;
      wr(`TCM_OFS_CTRL, 32'h60);
      rd(`TCM_OFS_CTRL);
      chk(v, 32'h60);
    end
  endtask : t_flags

  task automatic t_capture;
    logic [31:0] c;
    src_en <= 1'h1;
    for (int e = 1; e < 4; e++) begin
      c = 32'h40 | (32'(e) << 2);
      wr(`TCM_OFS_CH_CTRL, c);
      for (int l = 1; l >= 0; l--) begin
        src_lvl <= l[0];
        repeat (6) @(posedge hclk);
        chk(irq_request, l ? e[0] : e[1]);
        rd(`TCM_OFS_CH_CTRL);
        wr(`TCM_OFS_CH_CTRL, c);
        @(posedge hclk);
        chk(irq_request, 1'h0);
      end
    end
    // capture off first, so the release to the pull-up captures nothing
    wr(`TCM_OFS_CH_CTRL, 32'h0);
    src_en <= 1'h0;
  endtask : t_capture

  task automatic pwm(input logic [7:0] cfg, input logic [31:0] cv, input int n);
    wr(`TCM_OFS_CH_VALUE, cv);
    wr(`TCM_OFS_CH_CTRL, {24'h0, cfg});
    span(320);
    chk(rises >= n - 1 && rises <= n + 1, 32'h1);
  endtask : pwm

  task automatic t_compare;
    logic [7:0] cfg [6] = '{8'h00, 8'h10, 8'h18, 8'h1c, 8'h28, 8'h2c};
    logic [1:0] lvl [6] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
    wr(`TCM_OFS_CH_VALUE, 32'h8);
    wr(`TCM_OFS_CTRL, 32'h10);
    for (int i = 0; i < 6; i++) begin
      wr(`TCM_OFS_CH_CTRL, {24'h0, cfg[i]});
      repeat (40) @(posedge hclk);
      chk({pin_oe_n, pin_out}, lvl[i]);
    end
    pwm(8'h14, 32'h8, 10);
    pwm(8'h16, 32'hf, 10);
    pwm(8'h1a, 32'h8, 20);
    wr(`TCM_OFS_CH_CTRL, 32'h1b);
    span(64);
    chk(lows, 32'h0);
    wr(`TCM_OFS_CH_CTRL, 32'h1a);
    span(64);
    chk(lows > 0, 32'h1);
  endtask : t_compare

  // hang guard, far above the few thousand cycles needed
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_power();
    t_flags();
    t_capture();
    t_compare();
    results();
  end
endmodule : tb_top
